// file: core/reader_pkg.sv
// Shared constants, types and register map of the reader status and gate control block
package reader_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register byte offsets
  localparam logic [7:0] OFS_DEV_STATE = 8'h00;
  localparam logic [7:0] OFS_LINK_STATE = 8'h04;
  localparam logic [7:0] OFS_GATE_CTRL = 8'h08;
  localparam logic [7:0] OFS_PORT_DIR = 8'h0C;
  localparam logic [7:0] OFS_QUALITY = 8'h10;
  localparam logic [7:0] OFS_STATION = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;

  // Device state fields
  localparam int DEV_INIT_DONE_BIT = 0;
  localparam int DEV_SERVICE_BIT = 1;
  localparam int DEV_WARNING_BIT = 2;
  localparam int DEV_ERROR_BIT = 3;
  localparam int DEV_PARAM_EN_BIT = 4;
  localparam int DEV_W = 5;

  // Link state fields
  localparam int LINK_READY_BIT = 0;
  localparam int LINK_COMM_ERR_BIT = 1;
  localparam int LINK_NO_PROTO_BIT = 2;
  localparam int LINK_W = 3;

  // Gate control fields
  localparam int GATE_MODE_LSB = 0;
  localparam int GATE_HOST_OPEN_BIT = 2;

  // Quality fields
  localparam int QUAL_CFG_LSB = 0;
  localparam int QUAL_SEEN_LSB = 8;

  // Status fields (read only)
  localparam int ST_WINDOW_BIT = 0;
  localparam int ST_PWR_LSB = 1;
  localparam int ST_LINK_LSB = 3;
  localparam int ST_BACKLIGHT_BIT = 5;
  localparam int ST_NO_READ_BIT = 6;
  localparam int ST_ACTIVE_LSB = 8;
  localparam int ST_LEVEL_LSB = 12;
  localparam int ST_SEL_LSB = 16;
  localparam int ST_PERCENT_LSB = 24;

  // Reset values
  localparam logic [4:0] DEV_STATE_RST = 5'h00;
  localparam logic [2:0] LINK_STATE_RST = 3'h0;
  localparam logic [3:0] PORT_DIR_RST = 4'h8;
  localparam logic [7:0] STATION_RST = 8'h01;
  localparam logic [7:0] QUAL_CFG_RST = 8'h01;

  // Menu geometry
  localparam logic [1:0] MENU_LEVEL_MAX = 2'h3;
  localparam logic [2:0] MENU_ITEM_LAST = 3'h7;
  localparam logic [2:0] MENU_SAVE_ITEM = 3'h6;
  localparam logic [2:0] MENU_DELETE_ITEM = 3'h7;

  localparam logic [6:0] PERCENT_FULL = 7'h64;

  // Timing
  localparam longint CLK_HZ = 40000000;
  localparam longint BLINK_PERIOD_MS = 1000;
  localparam longint BACKLIGHT_MIN = 10;
  localparam longint BLINK_HALF_CYCLES = (BLINK_PERIOD_MS * CLK_HZ) / 2000;
  localparam longint BACKLIGHT_CYCLES = BACKLIGHT_MIN * 60 * CLK_HZ;

  // Pin sync vector layout
  localparam int SYNC_W = 10;
  localparam int SY_PORT_LSB = 0;
  localparam int SY_KEY_UP = 4;
  localparam int SY_KEY_DOWN = 5;
  localparam int SY_KEY_ENTER = 6;
  localparam int SY_KEY_BACK = 7;
  localparam int SY_REFLECTOR = 8;
  localparam int SY_PC = 9;

  typedef enum logic [1:0] {
    GATE_CYCLE = 2'b00,
    GATE_HOST = 2'b01,
    GATE_REFLECTOR = 2'b10
  } gate_mode_t;

  typedef struct packed {
    logic green;
    logic red;
  } lamp_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic commit;
    logic delete_char;
    logic enter_digit;
  } menu_event_t;

endpackage

// file: core/reader_status_gate.sv
// Status lamps, display indicators, menu keys and reading window control
//
// Functional notes
// R1: Init phase: power lamp flashes green, no reading
// R2: Init done: steady green, reading allowed
// R3: Service mode: orange, reading, no host data
// R4: Warning: power lamp flashes red, reading allowed
// R5: Error or parameter enable: steady red, blocked
// R6: Link initializing: link lamp flashes green
// R7: Link operating: link lamp steady green
// R8: Link communication fault: link lamp flashes red
// R9: No protocol connection: link lamp steady red
// R10: Any key keeps backlight on ten minutes
// R11: Up/down select, enter descends, back ascends
// R12: Commit only on save plus enter; delete
// R13: Ports default: 1,3 window, 2 teach, 4 noread
// R14: Activity indicator per switching port
// R15: Separate warning and error indicators
// R16: Read quality bar graph zero to hundred
// R17: Indicators for service computer and stick
// R18: Station address shown, resets to one
// R19: Reading only inside an open window
// R20: Cycle trigger default; host, reflector selectable
// R21: Reflector seen closes window, beam reduced
// R22: Flashing uses half-duty divided blink clock
// R23: Lamp shows most severe condition
`timescale 1ns/1ps
module reader_status_gate #(
  parameter logic [35:0] BACKLIGHT_CYCLES = 36'(reader_pkg::BACKLIGHT_CYCLES),
  parameter logic [24:0] BLINK_HALF_CYCLES = 25'(reader_pkg::BLINK_HALF_CYCLES)
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire reader_pkg::reg_req_t req,
  output logic [31:0] rdata,
  input wire logic [3:0] port_in,
  output logic [3:0] port_out,
  output logic [3:0] port_oe,
  input wire logic key_up_pin,
  input wire logic key_down_pin,
  input wire logic key_enter_pin,
  input wire logic menu_back_key,
  input wire logic reflector_seen_pin,
  input wire logic pc_attached_pin,
  input wire logic stick_attached_pin,
  input wire logic decode_good,
  output reader_pkg::lamp_t power_state_lamp,
  output reader_pkg::lamp_t link_state_lamp,
  output logic [3:0] port_active,
  output logic warning_indicator,
  output logic error_indicator,
  output logic pc_indicator,
  output logic param_stick_indicator,
  output logic [6:0] quality_percent,
  output logic [7:0] station_address,
  output logic backlight_on,
  output logic [1:0] menu_level,
  output logic [2:0] menu_sel,
  output reader_pkg::menu_event_t menu_event,
  output logic teach_pulse,
  output logic read_window_open,
  output logic beam_full_power,
  output logic host_tx_enable
);

  logic [4:0] dev_reg;
  logic [2:0] link_reg;
  logic [1:0] gate_mode_reg;
  logic host_open_reg;
  logic [3:0] port_dir_reg;
  logic [7:0] qual_cfg_reg;
  logic [7:0] qual_seen_reg;
  logic [7:0] station_reg;
  logic [reader_pkg::SYNC_W-1:0] sync_1_reg;
  logic [reader_pkg::SYNC_W-1:0] sync_2_reg;
  logic [3:0] key_prev_reg;
  logic port2_prev_reg;
  logic stick_1_reg;
  logic stick_2_reg;
  logic [24:0] blink_cnt_reg;
  logic blink_reg;
  logic [35:0] light_cnt_reg;
  logic window_next;
  logic good_seen_reg;
  logic no_read_reg;
  logic [31:0] status_word;
  logic [3:0] key_press;
  logic trig;
  logic read_allowed;
  logic dev_err;
  logic [14:0] q_prod;
  logic [14:0] q_div;
  logic [6:0] percent_next;
  reader_pkg::lamp_t pwr_next;
  reader_pkg::lamp_t link_next;

  // Register writes
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dev_reg <= reader_pkg::DEV_STATE_RST;
      link_reg <= reader_pkg::LINK_STATE_RST;
      gate_mode_reg <= reader_pkg::GATE_CYCLE; // R20
      host_open_reg <= 1'b0;
      port_dir_reg <= reader_pkg::PORT_DIR_RST; // R13
      qual_cfg_reg <= reader_pkg::QUAL_CFG_RST;
      qual_seen_reg <= 8'h00;
      station_reg <= reader_pkg::STATION_RST; // R18
    end else if (req.wr) begin
      case (req.addr)
        reader_pkg::OFS_DEV_STATE: dev_reg <= req.wdata[reader_pkg::DEV_W-1:0];
        reader_pkg::OFS_LINK_STATE: link_reg <= req.wdata[reader_pkg::LINK_W-1:0];
        reader_pkg::OFS_GATE_CTRL: begin
          gate_mode_reg <= req.wdata[reader_pkg::GATE_MODE_LSB +: 2];
          host_open_reg <= req.wdata[reader_pkg::GATE_HOST_OPEN_BIT];
        end
        reader_pkg::OFS_PORT_DIR: port_dir_reg <= req.wdata[3:0];
        reader_pkg::OFS_QUALITY: begin
          qual_cfg_reg <= req.wdata[reader_pkg::QUAL_CFG_LSB +: 8];
          qual_seen_reg <= req.wdata[reader_pkg::QUAL_SEEN_LSB +: 8];
        end
        reader_pkg::OFS_STATION: station_reg <= req.wdata[7:0];
        default: ;
      endcase
    end
  end

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[reader_pkg::ST_WINDOW_BIT] = read_window_open;
    status_word[reader_pkg::ST_PWR_LSB +: 2] = power_state_lamp;
    status_word[reader_pkg::ST_LINK_LSB +: 2] = link_state_lamp;
    status_word[reader_pkg::ST_BACKLIGHT_BIT] = backlight_on;
    status_word[reader_pkg::ST_NO_READ_BIT] = no_read_reg;
    status_word[reader_pkg::ST_ACTIVE_LSB +: 4] = port_active;
    status_word[reader_pkg::ST_LEVEL_LSB +: 2] = menu_level;
    status_word[reader_pkg::ST_SEL_LSB +: 3] = menu_sel;
    status_word[reader_pkg::ST_PERCENT_LSB +: 7] = quality_percent;
  end

  // Read data one cycle after the strobe; unmapped offsets read zero
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata <= 32'h0000_0000;
    end else if (req.rd) begin
      case (req.addr)
        reader_pkg::OFS_DEV_STATE: rdata <= {27'h0, dev_reg};
        reader_pkg::OFS_LINK_STATE: rdata <= {29'h0, link_reg};
        reader_pkg::OFS_GATE_CTRL: rdata <= {29'h0, host_open_reg, gate_mode_reg};
        reader_pkg::OFS_PORT_DIR: rdata <= {28'h0, port_dir_reg};
        reader_pkg::OFS_QUALITY: rdata <= {16'h0, qual_seen_reg, qual_cfg_reg};
        reader_pkg::OFS_STATION: rdata <= {24'h0, station_reg};
        reader_pkg::OFS_STATUS: rdata <= status_word;
        default: rdata <= 32'h0000_0000;
      endcase
    end else begin
      rdata <= 32'h0000_0000;
    end
  end

  // Pin synchronisers; first stage feeds only the second
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sync_1_reg <= '0;
      sync_2_reg <= '0;
      stick_1_reg <= 1'b0;
      stick_2_reg <= 1'b0;
    end else begin
      sync_1_reg <= {pc_attached_pin, reflector_seen_pin, menu_back_key, key_enter_pin,
                     key_down_pin, key_up_pin, port_in};
      sync_2_reg <= sync_1_reg;
      stick_1_reg <= stick_attached_pin;
      stick_2_reg <= stick_1_reg;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      key_prev_reg <= 4'h0;
      port2_prev_reg <= 1'b0;
    end else begin
      key_prev_reg <= sync_2_reg[reader_pkg::SY_KEY_UP +: 4];
      port2_prev_reg <= sync_2_reg[1];
    end
  end

  // No debounce: a bouncing key may count twice, acceptable for menu stepping
  assign key_press = sync_2_reg[reader_pkg::SY_KEY_UP +: 4] & ~key_prev_reg;

  // Blink divider
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      blink_cnt_reg <= 25'h0000000;
      blink_reg <= 1'b0;
    end else if (blink_cnt_reg == 25'h0000000) begin
      blink_cnt_reg <= BLINK_HALF_CYCLES - 25'h0000001; // R22
      blink_reg <= ~blink_reg; // R22
    end else begin
      blink_cnt_reg <= blink_cnt_reg - 25'h0000001;
    end
  end

  assign dev_err = dev_reg[reader_pkg::DEV_ERROR_BIT] | dev_reg[reader_pkg::DEV_PARAM_EN_BIT];
  assign read_allowed = dev_reg[reader_pkg::DEV_INIT_DONE_BIT] & ~dev_err; // R1 R5

  // Lamp priority, most severe first
  always_comb begin
    if (dev_err) begin
      pwr_next = '{green: 1'b0, red: 1'b1}; // R5 R23
    end else if (dev_reg[reader_pkg::DEV_WARNING_BIT]) begin
      pwr_next = '{green: 1'b0, red: blink_reg}; // R4
    end else if (dev_reg[reader_pkg::DEV_SERVICE_BIT]) begin
      pwr_next = '{green: 1'b1, red: 1'b1}; // R3
    end else if (!dev_reg[reader_pkg::DEV_INIT_DONE_BIT]) begin
      pwr_next = '{green: blink_reg, red: 1'b0}; // R1
    end else begin
      pwr_next = '{green: 1'b1, red: 1'b0}; // R2
    end
    if (link_reg[reader_pkg::LINK_NO_PROTO_BIT]) begin
      link_next = '{green: 1'b0, red: 1'b1}; // R9 R23
    end else if (link_reg[reader_pkg::LINK_COMM_ERR_BIT]) begin
      link_next = '{green: 1'b0, red: blink_reg}; // R8
    end else if (link_reg[reader_pkg::LINK_READY_BIT]) begin
      link_next = '{green: 1'b1, red: 1'b0}; // R7
    end else begin
      link_next = '{green: blink_reg, red: 1'b0}; // R6
    end
  end

  // Quality percentage; divider is combinational, it only feeds a slow display
  assign q_prod = 15'(qual_seen_reg) * 15'h0064;
  assign q_div = (qual_cfg_reg == 8'h00) ? 15'h0000 : q_prod / 15'(qual_cfg_reg);
  assign percent_next = (qual_seen_reg >= qual_cfg_reg) ? reader_pkg::PERCENT_FULL : q_div[6:0];

  // Display and lamp outputs
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      power_state_lamp <= '{green: 1'b0, red: 1'b0};
      link_state_lamp <= '{green: 1'b0, red: 1'b0};
      port_active <= 4'h0;
      warning_indicator <= 1'b0;
      error_indicator <= 1'b0;
      pc_indicator <= 1'b0;
      param_stick_indicator <= 1'b0;
      quality_percent <= 7'h00;
      station_address <= reader_pkg::STATION_RST;
      host_tx_enable <= 1'b0;
    end else begin
      power_state_lamp <= pwr_next;
      link_state_lamp <= link_next;
      port_active <= (port_dir_reg & {4{no_read_reg}}) | (~port_dir_reg & sync_2_reg[3:0]); // R14
      warning_indicator <= dev_reg[reader_pkg::DEV_WARNING_BIT]; // R15
      error_indicator <= dev_reg[reader_pkg::DEV_ERROR_BIT]; // R15
      pc_indicator <= sync_2_reg[reader_pkg::SY_PC]; // R17
      param_stick_indicator <= stick_2_reg; // R17
      quality_percent <= percent_next; // R16
      station_address <= station_reg; // R18
      host_tx_enable <= dev_reg[reader_pkg::DEV_INIT_DONE_BIT] & ~dev_reg[reader_pkg::DEV_SERVICE_BIT]; // R3
    end
  end

  // Backlight timer
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      light_cnt_reg <= 36'h000000000;
      backlight_on <= 1'b0;
    end else if (|key_press) begin
      light_cnt_reg <= BACKLIGHT_CYCLES; // R10
      backlight_on <= 1'b1;
    end else if (light_cnt_reg != 36'h000000000) begin
      light_cnt_reg <= light_cnt_reg - 36'h000000001;
      backlight_on <= (light_cnt_reg != 36'h000000001);
    end else begin
      backlight_on <= 1'b0;
    end
  end

  // Menu navigation; the deepest level is value entry
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      menu_level <= 2'h0;
      menu_sel <= 3'h0;
      menu_event <= '{commit: 1'b0, delete_char: 1'b0, enter_digit: 1'b0};
    end else begin
      menu_event <= '{commit: 1'b0, delete_char: 1'b0, enter_digit: 1'b0};
      if (key_press[3]) begin
        if (menu_level != 2'h0) begin
          menu_level <= menu_level - 2'h1; // R11
          menu_sel <= 3'h0;
        end
      end else if (key_press[2]) begin
        if (menu_level != reader_pkg::MENU_LEVEL_MAX) begin
          menu_level <= menu_level + 2'h1; // R11
          menu_sel <= 3'h0;
        end else if (menu_sel == reader_pkg::MENU_SAVE_ITEM) begin
          menu_event.commit <= 1'b1; // R12
        end else if (menu_sel == reader_pkg::MENU_DELETE_ITEM) begin
          menu_event.delete_char <= 1'b1; // R12
        end else begin
          menu_event.enter_digit <= 1'b1;
        end
      end else if (key_press[0]) begin
        menu_sel <= (menu_sel == 3'h0) ? reader_pkg::MENU_ITEM_LAST : menu_sel - 3'h1; // R11
      end else if (key_press[1]) begin
        menu_sel <= (menu_sel == reader_pkg::MENU_ITEM_LAST) ? 3'h0 : menu_sel + 3'h1; // R11
      end
    end
  end

  // Window trigger source
  always_comb begin
    case (gate_mode_reg)
      reader_pkg::GATE_CYCLE: trig = (sync_2_reg[0] & ~port_dir_reg[0]) | (sync_2_reg[2] & ~port_dir_reg[2]); // R20
      reader_pkg::GATE_HOST: trig = host_open_reg; // R20
      reader_pkg::GATE_REFLECTOR: trig = ~sync_2_reg[reader_pkg::SY_REFLECTOR]; // R21
      default: trig = 1'b0;
    endcase
  end

  assign window_next = read_allowed & trig; // R19

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      read_window_open <= 1'b0;
      beam_full_power <= 1'b0;
      good_seen_reg <= 1'b0;
      no_read_reg <= 1'b0;
      teach_pulse <= 1'b0;
    end else begin
      read_window_open <= window_next; // R19
      beam_full_power <= (gate_mode_reg != reader_pkg::GATE_REFLECTOR) | window_next; // R21
      if (!read_window_open && window_next) begin
        good_seen_reg <= 1'b0;
        no_read_reg <= 1'b0;
      end else if (read_window_open && !window_next) begin
        no_read_reg <= ~(good_seen_reg | decode_good); // R13
      end else if (read_window_open && decode_good) begin
        good_seen_reg <= 1'b1;
      end
      teach_pulse <= ~port_dir_reg[1] & sync_2_reg[1] & ~port2_prev_reg; // R13
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      port_out <= 4'h0;
      port_oe <= 4'h0;
    end else begin
      port_out <= port_dir_reg & {4{no_read_reg}}; // R13
      port_oe <= port_dir_reg;
    end
  end

  AST_INIT_NO_READ: assert property (@(posedge clk) disable iff (!rst_b) // R1
    !dev_reg[reader_pkg::DEV_INIT_DONE_BIT] |=> !read_window_open) else $error("window open during init");
  AST_ERROR_LAMP: assert property (@(posedge clk) disable iff (!rst_b) // R5
    dev_err |=> power_state_lamp.red && !power_state_lamp.green && !read_window_open)
    else $error("error state not steady red");
  AST_SERVICE_ORANGE: assert property (@(posedge clk) disable iff (!rst_b) // R3
    dev_reg == 5'h03 |=> power_state_lamp.red && power_state_lamp.green && !host_tx_enable)
    else $error("service mode not orange");
  AST_LINK_RED: assert property (@(posedge clk) disable iff (!rst_b) // R9
    link_reg[reader_pkg::LINK_NO_PROTO_BIT] |=> link_state_lamp == '{green: 1'b0, red: 1'b1})
    else $error("link not steady red");
  AST_BACKLIGHT: assert property (@(posedge clk) disable iff (!rst_b) // R10
    |key_press |=> backlight_on [*8]) else $error("backlight dropped after key");
  AST_HOST_WINDOW: assert property (@(posedge clk) disable iff (!rst_b) // R20
    gate_mode_reg == reader_pkg::GATE_HOST && host_open_reg && read_allowed |=> read_window_open)
    else $error("host command did not open window");
  AST_REFLECTOR: assert property (@(posedge clk) disable iff (!rst_b) // R21
    gate_mode_reg == reader_pkg::GATE_REFLECTOR && sync_2_reg[reader_pkg::SY_REFLECTOR]
    |=> !read_window_open && !beam_full_power) else $error("window open while reflector seen");
  AST_BLINK: assert property (@(posedge clk) disable iff (!rst_b) // R22
    $changed(blink_reg) |-> $past(blink_cnt_reg) == 25'h0000000) else $error("blink toggled early");
  AST_COMMIT: assert property (@(posedge clk) disable iff (!rst_b) // R12
    menu_event.commit |-> $past(key_press[2]) && $past(menu_sel) == reader_pkg::MENU_SAVE_ITEM
    && $past(menu_level) == reader_pkg::MENU_LEVEL_MAX) else $error("commit without save");
  AST_QUALITY: assert property (@(posedge clk) disable iff (!rst_b) // R16
    quality_percent <= reader_pkg::PERCENT_FULL) else $error("quality above full scale");

endmodule

// file: dv/operator_side.sv
// Model of operator keys, trigger pins, reflector and service port devices
`timescale 1ns/1ps
module operator_side (
  input wire logic clk,
  output logic [3:0] port_in,
  output logic [3:0] keys,
  output logic reflector_seen_pin,
  output logic pc_attached_pin,
  output logic stick_attached_pin
);
  initial begin
    port_in = 4'h0;
    keys = 4'h0;
    reflector_seen_pin = 1'h1;
    pc_attached_pin = 1'h0;
    stick_attached_pin = 1'h0;
  end
  // Levels change just after an edge, as a field device would present them
  task automatic drive(input logic [3:0] p, input logic r, input logic pc, input logic st);
    @(posedge clk);
    port_in <= p;
    reflector_seen_pin <= r;
    pc_attached_pin <= pc;
    stick_attached_pin <= st;
  endtask
  // Held two cycles: keys have no debounce, only a two-stage synchroniser
  task automatic press(input int k);
    @(posedge clk);
    keys[k] <= 1'h1;
    repeat (2) @(posedge clk);
    keys[k] <= 1'h0;
    repeat (3) @(posedge clk);
    #1;
  endtask
endmodule

// file: dv/tb_top.sv
// Self-checking bench for the reader status and gate block
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'h0;
  logic rst_b = 1'h0;
  reader_pkg::reg_req_t req = '0;
  logic decode_good = 1'h0;
  logic [31:0] rdata;
  logic [3:0] port_in, port_out, port_oe, keys, port_active;
  logic key_up_pin, key_down_pin, key_enter_pin, menu_back_key;
  logic reflector_seen_pin, pc_attached_pin, stick_attached_pin;
  reader_pkg::lamp_t power_state_lamp, link_state_lamp;
  logic warning_indicator, error_indicator, pc_indicator, param_stick_indicator;
  logic backlight_on, teach_pulse, read_window_open, beam_full_power, host_tx_enable;
  logic [6:0] quality_percent;
  logic [7:0] station_address;
  logic [1:0] menu_level;
  logic [2:0] menu_sel;
  reader_pkg::menu_event_t menu_event;
  logic [2:0] ev_acc = 3'h0;
  logic tp_seen = 1'h0;
  int n_errors = 0;
  int compares = 0;

  always #12.5 clk = ~clk;

  // Short counts keep blink and backlight checks within a few dozen cycles
  assign {menu_back_key, key_enter_pin, key_down_pin, key_up_pin} = keys;

  reader_status_gate #(.BACKLIGHT_CYCLES(36'h14), .BLINK_HALF_CYCLES(25'h4)) u_reader_status_gate (
    .clk(clk), .rst_b(rst_b), .req(req), .rdata(rdata), .port_in(port_in), .port_out(port_out),
    .port_oe(port_oe), .key_up_pin(key_up_pin), .key_down_pin(key_down_pin), .key_enter_pin(key_enter_pin),
    .menu_back_key(menu_back_key), .reflector_seen_pin(reflector_seen_pin), .pc_attached_pin(pc_attached_pin),
    .stick_attached_pin(stick_attached_pin), .decode_good(decode_good), .power_state_lamp(power_state_lamp),
    .link_state_lamp(link_state_lamp), .port_active(port_active), .warning_indicator(warning_indicator),
    .error_indicator(error_indicator), .pc_indicator(pc_indicator), .param_stick_indicator(param_stick_indicator),
    .quality_percent(quality_percent), .station_address(station_address), .backlight_on(backlight_on),
    .menu_level(menu_level), .menu_sel(menu_sel), .menu_event(menu_event), .teach_pulse(teach_pulse),
    .read_window_open(read_window_open), .beam_full_power(beam_full_power), .host_tx_enable(host_tx_enable)
  );

  operator_side u_operator_side (
    .clk(clk), .port_in(port_in), .keys(keys), .reflector_seen_pin(reflector_seen_pin),
    .pc_attached_pin(pc_attached_pin), .stick_attached_pin(stick_attached_pin)
  );

  // One-cycle pulses are collected so a task can judge them after the fact
  always @(posedge clk) begin
    ev_acc <= ev_acc | menu_event;
    tp_seen <= tp_seen | teach_pulse;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic clr();
    #1;
    ev_acc = 3'h0;
    tp_seen = 1'h0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= 1'h1;
    @(posedge clk);
    req.wr <= 1'h0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    req.addr <= a;
    req.rd <= 1'h1;
    @(posedge clk);
    req.rd <= 1'h0;
    #1;
    chk(rdata, exp);
  endtask

  // Counts lit cycles over two blink periods: 16 steady, 8 flashing, 0 dark
  task automatic lamp(input bit link, input int g, input int r);
    logic [31:0] ng;
    logic [31:0] nr;
    ng = 0;
    nr = 0;
    wt(2);
    for (int i = 0; i < 16; i++) begin
      wt(1);
      ng = ng + (link ? link_state_lamp.green : power_state_lamp.green);
      nr = nr + (link ? link_state_lamp.red : power_state_lamp.red);
    end
    chk(ng, g);
    chk(nr, r);
  endtask

  task automatic t_reset();
    chk(station_address, 8'h01);
    chk(port_oe, 4'h8);
    rd_chk(reader_pkg::OFS_STATION, 32'h1);
    rd_chk(reader_pkg::OFS_PORT_DIR, 32'h8);
    rd_chk(8'hFC, 32'h0);
    lamp(0, 8, 0);
    lamp(1, 8, 0);
    u_operator_side.drive(4'h1, 1'h1, 1'h0, 1'h0);
    wt(5);
    chk(read_window_open, 1'h0);
    u_operator_side.drive(4'h0, 1'h1, 1'h0, 1'h0);
  endtask

  task automatic t_lamps();
    wr(reader_pkg::OFS_DEV_STATE, 32'h01);
    lamp(0, 16, 0);
    chk(host_tx_enable, 1'h1);
    wr(reader_pkg::OFS_DEV_STATE, 32'h03);
    lamp(0, 16, 16);
    chk(host_tx_enable, 1'h0);
    wr(reader_pkg::OFS_DEV_STATE, 32'h05);
    lamp(0, 0, 8);
    chk(warning_indicator, 1'h1);
    chk(error_indicator, 1'h0);
    wr(reader_pkg::OFS_DEV_STATE, 32'h07);
    lamp(0, 0, 8);
    wr(reader_pkg::OFS_DEV_STATE, 32'h0D);
    lamp(0, 0, 16);
    chk(error_indicator, 1'h1);
    wr(reader_pkg::OFS_DEV_STATE, 32'h11);
    lamp(0, 0, 16);
    wr(reader_pkg::OFS_LINK_STATE, 32'h1);
    lamp(1, 16, 0);
    wr(reader_pkg::OFS_LINK_STATE, 32'h3);
    lamp(1, 0, 8);
    wr(reader_pkg::OFS_LINK_STATE, 32'h7);
    lamp(1, 0, 16);
  endtask

  task automatic t_display();
    wr(reader_pkg::OFS_QUALITY, 32'h0204);
    wt(3);
    chk(quality_percent, 7'h32);
    wr(reader_pkg::OFS_QUALITY, 32'h0904);
    wr(reader_pkg::OFS_STATION, 32'h1F);
    wt(3);
    chk(quality_percent, 7'h64);
    chk(station_address, 8'h1F);
    u_operator_side.drive(4'h0, 1'h1, 1'h1, 1'h0);
    wt(5);
    chk({pc_indicator, param_stick_indicator}, 2'h2);
    u_operator_side.drive(4'h0, 1'h1, 1'h0, 1'h1);
    wt(5);
    chk({pc_indicator, param_stick_indicator}, 2'h1);
  endtask

  task automatic t_cycle();
    wr(reader_pkg::OFS_DEV_STATE, 32'h01);
    wr(reader_pkg::OFS_GATE_CTRL, 32'h0);
    clr();
    u_operator_side.drive(4'h2, 1'h1, 1'h0, 1'h0);
    wt(5);
    chk(tp_seen, 1'h1);
    chk(port_active, 4'h2);
    chk(read_window_open, 1'h0);
    u_operator_side.drive(4'h1, 1'h1, 1'h0, 1'h0);
    wt(4);
    chk({read_window_open, beam_full_power}, 2'h3);
    chk(port_active, 4'h1);
    u_operator_side.drive(4'h0, 1'h1, 1'h0, 1'h0);
    wt(6);
    chk(read_window_open, 1'h0);
    chk(port_out[3], 1'h1);
    u_operator_side.drive(4'h4, 1'h1, 1'h0, 1'h0);
    wt(4);
    chk(read_window_open, 1'h1);
    @(posedge clk);
    decode_good <= 1'h1;
    @(posedge clk);
    decode_good <= 1'h0;
    u_operator_side.drive(4'h0, 1'h1, 1'h0, 1'h0);
    wt(6);
    chk(port_out[3], 1'h0);
    wr(reader_pkg::OFS_DEV_STATE, 32'h09);
    u_operator_side.drive(4'h1, 1'h1, 1'h0, 1'h0);
    wt(5);
    chk(read_window_open, 1'h0);
    u_operator_side.drive(4'h0, 1'h1, 1'h0, 1'h0);
  endtask

  task automatic t_modes();
    wr(reader_pkg::OFS_DEV_STATE, 32'h01);
    wr(reader_pkg::OFS_GATE_CTRL, 32'h1);
    u_operator_side.drive(4'h1, 1'h1, 1'h0, 1'h0);
    wt(5);
    chk(read_window_open, 1'h0);
    wr(reader_pkg::OFS_GATE_CTRL, 32'h5);
    wt(3);
    chk(read_window_open, 1'h1);
    u_operator_side.drive(4'h0, 1'h1, 1'h0, 1'h0);
    wr(reader_pkg::OFS_GATE_CTRL, 32'h2);
    wt(4);
    chk({read_window_open, beam_full_power}, 2'h0);
    u_operator_side.drive(4'h0, 1'h0, 1'h0, 1'h0);
    wt(4);
    chk({read_window_open, beam_full_power}, 2'h3);
    u_operator_side.drive(4'h0, 1'h1, 1'h0, 1'h0);
    wt(4);
    chk({read_window_open, beam_full_power}, 2'h0);
    wr(reader_pkg::OFS_GATE_CTRL, 32'h7);
    u_operator_side.drive(4'h5, 1'h0, 1'h0, 1'h0);
    wt(5);
    chk(read_window_open, 1'h0);
    u_operator_side.drive(4'h0, 1'h1, 1'h0, 1'h0);
  endtask

  task automatic t_keys();
    u_operator_side.press(0);
    chk({menu_level, menu_sel}, 5'h07);
    chk(backlight_on, 1'h1);
    wt(10);
    u_operator_side.press(1);
    chk({menu_level, menu_sel}, 5'h00);
    wt(10);
    chk(backlight_on, 1'h1);
    wt(15);
    chk(backlight_on, 1'h0);
    for (int i = 0; i < 3; i++) u_operator_side.press(2);
    chk({menu_level, menu_sel}, 5'h18);
    for (int i = 0; i < 2; i++) u_operator_side.press(0);
    clr();
    u_operator_side.press(2);
    chk(ev_acc, 3'h4);
    u_operator_side.press(1);
    clr();
    u_operator_side.press(2);
    chk(ev_acc, 3'h2);
    u_operator_side.press(1);
    clr();
    u_operator_side.press(2);
    chk(ev_acc, 3'h1);
    u_operator_side.press(3);
    chk(menu_level, 2'h2);
  endtask

  task automatic end_sim();
    $display("Errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge clk);
    rst_b <= 1'h1;
    wt(1);
    t_reset();
    t_lamps();
    t_display();
    t_cycle();
    t_modes();
    t_keys();
    end_sim();
  end

  // Whole run needs about five hundred cycles; the 20000-cycle limit leaves ample margin
  initial begin
    #500000;
    n_errors++;
    end_sim();
  end
endmodule
